/* File: nrmc_pkg.sv */
// Offsets, field positions and fixed values of the remap and MSI registers
package nrmc_pkg;
    localparam int CFG_ADDR_W = 12;
    localparam int WIN_LOW_LSB = 20;
    localparam int WIN_LOW_W = 12;
    localparam logic [11:0] OFS_CAP_PTR = 12'h034;
    localparam logic [11:0] OFS_PRI_BASE_HIGH = 12'h06c;
    localparam logic [11:0] OFS_SEC_BASE_LOW = 12'h070;
    localparam logic [11:0] OFS_SEC_BASE_HIGH = 12'h074;
    localparam logic [11:0] OFS_SEC_LIMIT_LOW = 12'h078;
    localparam logic [11:0] OFS_SEC_LIMIT_HIGH = 12'h07c;
    localparam logic [11:0] OFS_MSI_HDR = 12'h080;
    localparam logic [11:0] OFS_EXT_CAP_FIRST = 12'h100;
    localparam logic [31:0] RST_REMAP = 32'h00000000;
    localparam logic [31:0] RST_MSI_HDR = 32'h0186a005;
    localparam int CAP_IDENT_LSB = 0;
    localparam int NEXT_PTR_LSB = 8;
    localparam int MSG_EN_BIT = 16;
    localparam int VEC_REQ_LSB = 17;
    localparam int VEC_ALLOC_LSB = 20;
    localparam int WIDE_BIT = 23;
    localparam int VEC_MASK_BIT = 24;
    localparam logic [7:0] CAP_IDENT_MSI = 8'h05;
    localparam logic [7:0] NEXT_CAP_PTR = 8'ha0;
    localparam logic [2:0] VEC_REQ_CODE = 3'h3;
    localparam logic [2:0] VEC_ALLOC_MAX = 3'h3;
    localparam logic [7:0] CAP_LIST_START_DEF = 8'h80;
    localparam logic [19:0] WIN_LOW_FILL = 20'hfffff;
endpackage : nrmc_pkg

/* File: nrmc_win_if.sv */
// Remap window settings passed from the register bank to the matcher
interface nrmc_win_if;
    logic enable;
    logic [63:0] secBase;
    logic [63:0] secLimit;
    logic [63:0] priBase;
    modport src (output enable, output secBase, output secLimit,
        output priBase);
    modport sink (input enable, input secBase, input secLimit,
        input priBase);
endinterface : nrmc_win_if

/* File: nrmc_window_match.sv */
// Secondary window hit test and address translation
module nrmc_window_match
    import nrmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    nrmc_win_if.sink win,
    input wire logic txnValid,
    input wire logic [63:0] txnAddr,
    output logic xlatValid,
    output logic xlatHit,
    output logic [63:0] xlatAddr
);
    logic xlatValid_reg, xlatValid_next;
    logic xlatHit_reg, xlatHit_next;
    logic [63:0] xlatAddr_reg, xlatAddr_next;
    logic inWindow;

    always_comb begin
        inWindow = (txnAddr >= win.secBase) && (txnAddr <= win.secLimit);
        xlatValid_next = xlatValid_reg;
        xlatHit_next = xlatHit_reg;
        xlatAddr_next = xlatAddr_reg;
        if (ce) begin
            xlatValid_next = txnValid;
            xlatHit_next = txnValid && win.enable && inWindow;
            if (txnValid && win.enable && inWindow) begin
                xlatAddr_next = win.priBase + (txnAddr - win.secBase);
            end else if (txnValid) begin
                xlatAddr_next = txnAddr;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xlatValid_reg <= 1'b0;
            xlatHit_reg <= 1'b0;
            xlatAddr_reg <= 64'h0;
        end else begin
            xlatValid_reg <= xlatValid_next;
            xlatHit_reg <= xlatHit_next;
            xlatAddr_reg <= xlatAddr_next;
        end
    end

    assign xlatValid = xlatValid_reg;
    assign xlatHit = xlatHit_reg;
    assign xlatAddr = xlatAddr_reg;

    a_remap_disabled_miss: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && txnValid && !win.enable |=> xlatValid && !xlatHit)
        else $error("hit reported while remapping disabled");

    a_window_hit_addr: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && txnValid && win.enable && txnAddr == win.secBase
        && win.secBase <= win.secLimit
        |=> xlatHit && xlatAddr == $past(win.priBase))
        else $error("window base not mapped to primary base");

    a_window_bounds: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && txnValid && win.enable
        && (txnAddr < win.secBase || txnAddr > win.secLimit)
        |=> !xlatHit && xlatAddr == $past(txnAddr))
        else $error("address outside window treated as hit");
endmodule : nrmc_window_match

/* File: nrmc_cap_regs.sv */
// Remap window and MSI capability header configuration registers
//
// Functional notes
// - Primary upper base at 0x06c, 32-bit read/write, resets to zero.
// - Secondary lower base bits 31:20 writable; bits 19:0 read zero.
// - Secondary upper base at 0x074, 32-bit read/write, resets to zero.
// - Secondary lower limit bits 31:20 writable; bits 19:0 read zero.
// - Secondary upper limit at 0x07c, 32-bit read/write, resets to zero.
// - First extended capability always sits at offset 0x100.
// - Offset 0x034 reports where the capability list starts.
// - Capability identifier 0x05 read-only in header bits 7:0.
// - Next capability pointer 0xa0 read-only in bits 15:8.
// - Bit 24 reads one: per-vector masking supported.
// - Bit 23 reads one: 64-bit message address supported.
// - Allocated vectors code in bits 22:20, writable, decodes 1,2,4,8.
// - Requested vectors code reads 3, meaning eight vectors.
// - Enable bit 16 writable; zero permits MSI, one forbids it.
// - Remapping happens only while the remap enable is set.
// - Window hits are translated using the primary upper base register and the remapLowerBasePrimary input.
module nrmc_cap_regs
    import nrmc_pkg::*;
#(
    parameter logic [7:0] CAP_LIST_START = CAP_LIST_START_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire logic [CFG_ADDR_W-1:0] cfgAddr,
    input wire logic [31:0] cfgWrData,
    input wire logic [3:0] cfgByteEn,
    output logic [31:0] cfgRdData,
    output logic cfgRdValid,
    input wire logic remapEnable,
    input wire logic [WIN_LOW_W-1:0] remapLowerBasePrimary,
    input wire logic txnValid,
    input wire logic [63:0] txnAddr,
    output logic xlatValid,
    output logic xlatHit,
    output logic [63:0] xlatAddr,
    output logic msgIntEnable,
    output logic msgIntPermitted,
    output logic [2:0] vectorsAllocated,
    output logic [3:0] vectorsAllocatedCount,
    output logic [CFG_ADDR_W-1:0] firstExtCapOffset,
    output logic [7:0] capListStart
);
    logic [31:0] priBaseHigh_reg, priBaseHigh_next;
    logic [WIN_LOW_W-1:0] secBaseLow_reg, secBaseLow_next;
    logic [31:0] secBaseHigh_reg, secBaseHigh_next;
    logic [WIN_LOW_W-1:0] secLimitLow_reg, secLimitLow_next;
    logic [31:0] secLimitHigh_reg, secLimitHigh_next;
    logic [2:0] vecAlloc_reg, vecAlloc_next;
    logic msgEn_reg, msgEn_next;
    logic [31:0] rdData_reg, rdData_next;
    logic rdValid_reg, rdValid_next;
    logic [31:0] hdrWord;
    logic [3:0] countDecoded;
    logic [3:0] countDecoded_reg;

    nrmc_win_if winBus ();

    // Merge the enabled byte lanes of a write into the old word
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
        input logic [31:0] newV, input logic [3:0] be);
        logic [31:0] r;
        r = oldV;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = newV[8*i +: 8];
            end
        end
        return r;
    endfunction : mergeBytes

    always_comb begin
        hdrWord = 32'h0;
        hdrWord[CAP_IDENT_LSB +: 8] = CAP_IDENT_MSI;
        hdrWord[NEXT_PTR_LSB +: 8] = NEXT_CAP_PTR;
        hdrWord[MSG_EN_BIT] = msgEn_reg;
        hdrWord[VEC_REQ_LSB +: 3] = VEC_REQ_CODE;
        hdrWord[VEC_ALLOC_LSB +: 3] = vecAlloc_reg;
        hdrWord[WIDE_BIT] = 1'b1;
        hdrWord[VEC_MASK_BIT] = 1'b1;
    end

    always_comb begin
        if (vecAlloc_reg <= VEC_ALLOC_MAX) begin
            countDecoded = 4'h1 << vecAlloc_reg;
        end else begin
            countDecoded = 4'h0;
        end
    end

    // Register writes; fixed and reserved bits are never stored
    always_comb begin
        logic [31:0] m;
        m = 32'h0;
        priBaseHigh_next = priBaseHigh_reg;
        secBaseLow_next = secBaseLow_reg;
        secBaseHigh_next = secBaseHigh_reg;
        secLimitLow_next = secLimitLow_reg;
        secLimitHigh_next = secLimitHigh_reg;
        vecAlloc_next = vecAlloc_reg;
        msgEn_next = msgEn_reg;
        if (ce && cfgWrEn) begin
            unique case (cfgAddr)
                OFS_PRI_BASE_HIGH: begin
                    priBaseHigh_next = mergeBytes(priBaseHigh_reg,
                        cfgWrData, cfgByteEn);
                end
                OFS_SEC_BASE_LOW: begin
                    m = mergeBytes({secBaseLow_reg, 20'h0}, cfgWrData,
                        cfgByteEn);
                    secBaseLow_next = m[WIN_LOW_LSB +: WIN_LOW_W];
                end
                OFS_SEC_BASE_HIGH: begin
                    secBaseHigh_next = mergeBytes(secBaseHigh_reg,
                        cfgWrData, cfgByteEn);
                end
                OFS_SEC_LIMIT_LOW: begin
                    m = mergeBytes({secLimitLow_reg, 20'h0}, cfgWrData,
                        cfgByteEn);
                    secLimitLow_next = m[WIN_LOW_LSB +: WIN_LOW_W];
                end
                OFS_SEC_LIMIT_HIGH: begin
                    secLimitHigh_next = mergeBytes(secLimitHigh_reg,
                        cfgWrData, cfgByteEn);
                end
                // only enable and allocation bits taken
                OFS_MSI_HDR: begin
                    m = mergeBytes(hdrWord, cfgWrData, cfgByteEn);
                    vecAlloc_next = m[VEC_ALLOC_LSB +: 3];
                    msgEn_next = m[MSG_EN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Read answer, one cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdData_next = rdData_reg;
        rdValid_next = rdValid_reg;
        if (ce) begin
            rdValid_next = cfgRdEn;
            if (cfgRdEn) begin
                unique case (cfgAddr)
                    OFS_CAP_PTR: rdData_next = {24'h0, CAP_LIST_START};
                    OFS_PRI_BASE_HIGH: rdData_next = priBaseHigh_reg;
                    OFS_SEC_BASE_LOW: rdData_next = {secBaseLow_reg, 20'h0};
                    OFS_SEC_BASE_HIGH: rdData_next = secBaseHigh_reg;
                    OFS_SEC_LIMIT_LOW: rdData_next = {secLimitLow_reg, 20'h0};
                    OFS_SEC_LIMIT_HIGH: rdData_next = secLimitHigh_reg;
                    OFS_MSI_HDR: rdData_next = hdrWord;
                    default: rdData_next = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            priBaseHigh_reg <= RST_REMAP;
            secBaseLow_reg <= RST_REMAP[WIN_LOW_LSB +: WIN_LOW_W];
            secBaseHigh_reg <= RST_REMAP;
            secLimitLow_reg <= RST_REMAP[WIN_LOW_LSB +: WIN_LOW_W];
            secLimitHigh_reg <= RST_REMAP;
            vecAlloc_reg <= RST_MSI_HDR[VEC_ALLOC_LSB +: 3];
            msgEn_reg <= RST_MSI_HDR[MSG_EN_BIT];
            rdData_reg <= 32'h0;
            rdValid_reg <= 1'b0;
            countDecoded_reg <= 4'h1;
        end else begin
            priBaseHigh_reg <= priBaseHigh_next;
            secBaseLow_reg <= secBaseLow_next;
            secBaseHigh_reg <= secBaseHigh_next;
            secLimitLow_reg <= secLimitLow_next;
            secLimitHigh_reg <= secLimitHigh_next;
            vecAlloc_reg <= vecAlloc_next;
            msgEn_reg <= msgEn_next;
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
            if (ce) begin
                countDecoded_reg <= countDecoded;
            end
        end
    end

    // limit covers the whole last 1 MB block
    assign winBus.secBase = {secBaseHigh_reg, secBaseLow_reg, 20'h0};
    assign winBus.secLimit = {secLimitHigh_reg, secLimitLow_reg,
        WIN_LOW_FILL};
    assign winBus.priBase = {priBaseHigh_reg, remapLowerBasePrimary,
        20'h0};
    assign winBus.enable = remapEnable;

    nrmc_window_match u_match (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .win(winBus),
        .txnValid(txnValid),
        .txnAddr(txnAddr),
        .xlatValid(xlatValid),
        .xlatHit(xlatHit),
        .xlatAddr(xlatAddr)
    );

    assign cfgRdData = rdData_reg;
    assign cfgRdValid = rdValid_reg;
    assign msgIntEnable = msgEn_reg;
    // inverted sense of the enable bit
    assign msgIntPermitted = !msgEn_reg;
    assign vectorsAllocated = vecAlloc_reg;
    assign vectorsAllocatedCount = countDecoded_reg;
    assign firstExtCapOffset = OFS_EXT_CAP_FIRST;
    assign capListStart = CAP_LIST_START;

    a_pri_high_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgWrEn && cfgAddr == OFS_PRI_BASE_HIGH && cfgByteEn == 4'hf
        |=> priBaseHigh_reg == $past(cfgWrData))
        else $error("primary upper base not stored");

    a_base_low_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgRdEn && cfgAddr == OFS_SEC_BASE_LOW
        |=> cfgRdValid && cfgRdData[19:0] == 20'h0
        && cfgRdData[31:20] == $past(secBaseLow_reg))
        else $error("secondary lower base read wrong");

    a_base_high_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgWrEn && cfgAddr == OFS_SEC_BASE_HIGH && cfgByteEn == 4'hf
        ##1 ce && cfgRdEn && cfgAddr == OFS_SEC_BASE_HIGH
        |=> cfgRdData == $past(cfgWrData, 2))
        else $error("secondary upper base readback wrong");

    a_limit_low_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgWrEn && cfgAddr == OFS_SEC_LIMIT_LOW && cfgByteEn == 4'hf
        |=> secLimitLow_reg == $past(cfgWrData[31:20]))
        else $error("secondary lower limit not stored");

    a_limit_high_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgWrEn && cfgAddr == OFS_SEC_LIMIT_HIGH && cfgByteEn == 4'hf
        |=> secLimitHigh_reg == $past(cfgWrData))
        else $error("secondary upper limit not stored");

    a_ext_cap_fixed: assert property (
        @(posedge clk) disable iff (!rst_n)
        firstExtCapOffset == 12'h100)
        else $error("extended capability moved");

    a_cap_ptr_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgRdEn && cfgAddr == OFS_CAP_PTR
        |=> cfgRdValid && cfgRdData == {24'h0, CAP_LIST_START})
        else $error("capability pointer read wrong");

    a_hdr_fixed_fields: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgRdEn && cfgAddr == OFS_MSI_HDR
        |=> cfgRdData[7:0] == 8'h05 && cfgRdData[15:8] == 8'ha0
        && cfgRdData[24:23] == 2'h3 && cfgRdData[19:17] == 3'h3
        && cfgRdData[31:25] == 7'h0)
        else $error("fixed header fields read wrong");

    a_hdr_write_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgWrEn && cfgAddr == OFS_MSI_HDR && cfgByteEn == 4'hf
        ##1 ce && cfgRdEn && cfgAddr == OFS_MSI_HDR
        |=> cfgRdData[15:0] == 16'ha005
        && cfgRdData[22:16] == {$past(cfgWrData[22:20], 2), 3'h3,
        $past(cfgWrData[16], 2)})
        else $error("header write reached fixed bits");

    a_vec_count: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgWrEn && cfgAddr == OFS_MSI_HDR && cfgByteEn[2]
        && cfgWrData[22:20] == 3'h3 ##1 ce
        |=> vectorsAllocatedCount == 4'h8)
        else $error("allocated vector count decode wrong");

    a_msi_forbid: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && cfgWrEn && cfgAddr == OFS_MSI_HDR && cfgByteEn[2]
        |=> msgIntPermitted == !$past(cfgWrData[16])
        && msgIntEnable == $past(cfgWrData[16]))
        else $error("message enable sense wrong");

    a_freeze_ce: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ce |=> $stable(priBaseHigh_reg) && $stable(vecAlloc_reg)
        && $stable(cfgRdValid))
        else $error("state moved with clock enable low");
endmodule : nrmc_cap_regs

/* File: test_nrmc_cap_regs.sv */
// Self-checking bench for the remap window and MSI header register bank
module test_nrmc_cap_regs
    import nrmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] LIST_START = 8'h80;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic cfgWrEn = 1'b0;
    logic cfgRdEn = 1'b0;
    logic [11:0] cfgAddr = 12'h000;
    logic [31:0] cfgWrData = 32'h0;
    logic [3:0] cfgByteEn = 4'h0;
    logic [31:0] cfgRdData;
    logic cfgRdValid;
    logic remapEnable = 1'b0;
    logic [11:0] remapLowerBasePrimary = 12'h000;
    logic txnValid = 1'b0;
    logic [63:0] txnAddr = 64'h0;
    logic xlatValid;
    logic xlatHit;
    logic [63:0] xlatAddr;
    logic msgIntEnable;
    logic msgIntPermitted;
    logic [2:0] vectorsAllocated;
    logic [3:0] vectorsAllocatedCount;
    logic [11:0] firstExtCapOffset;
    logic [7:0] capListStart;
    int badCount = 0;
    int totalChecks = 0;
    logic [11:0] ofs [6] = '{OFS_PRI_BASE_HIGH, OFS_SEC_BASE_LOW,
        OFS_SEC_BASE_HIGH, OFS_SEC_LIMIT_LOW, OFS_SEC_LIMIT_HIGH, OFS_MSI_HDR};
    logic [31:0] wmask [6] = '{32'hffffffff, 32'hfff00000, 32'hffffffff,
        32'hfff00000, 32'hffffffff, 32'h00710000};
    logic [31:0] mdl [6];

    nrmc_cap_regs #(.CAP_LIST_START(LIST_START)) u_dut (.clk(clk),
        .rst_n(rst_n), .ce(ce), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .remapEnable(remapEnable),
        .remapLowerBasePrimary(remapLowerBasePrimary),
        .txnValid(txnValid), .txnAddr(txnAddr), .xlatValid(xlatValid),
        .xlatHit(xlatHit), .xlatAddr(xlatAddr), .msgIntEnable(msgIntEnable),
        .msgIntPermitted(msgIntPermitted),
        .vectorsAllocated(vectorsAllocated),
        .vectorsAllocatedCount(vectorsAllocatedCount),
        .firstExtCapOffset(firstExtCapOffset), .capListStart(capListStart));

    always #4 clk = ~clk;

    task automatic endSim();
        $display("Checks %0d, mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : endSim

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
            input string what);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got,
                exp);
        end
    endtask : chk

    function automatic int idxOf(input logic [11:0] a);
        for (int i = 0; i < 6; i++) begin
            if (ofs[i] == a) return i;
        end
        return -1;
    endfunction : idxOf

    function automatic logic [31:0] expRead(input logic [11:0] a);
        int i = idxOf(a);
        if (a == OFS_CAP_PTR) return {24'h0, LIST_START};
        return (i < 0) ? 32'h0 : mdl[i];
    endfunction : expRead

    // Drives one bus cycle from a falling edge to the next
    task automatic acc(input logic w, input logic r, input logic [11:0] a,
            input logic [31:0] d, input logic [3:0] be);
        @(negedge clk);
        cfgWrEn = w;
        cfgRdEn = r;
        cfgAddr = a;
        cfgWrData = d;
        cfgByteEn = be;
        @(negedge clk);
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
    endtask : acc

    task automatic mdlWrite(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] be);
        int i;
        logic [31:0] m;
        i = idxOf(a);
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (i >= 0) begin
            m = m & wmask[i];
            mdl[i] = (mdl[i] & ~m) | (d & m);
        end
    endtask : mdlWrite

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] be);
        acc(1'b1, 1'b0, a, d, be);
        mdlWrite(a, d, be);
        chk(cfgRdValid, 1'b0, "valid after write");
    endtask : wr

    task automatic rdChk(input logic [11:0] a);
        acc(1'b0, 1'b1, a, 32'h0, 4'h0);
        chk(cfgRdValid, 1'b1, "read valid");
        chk(cfgRdData, expRead(a), "read data");
    endtask : rdChk

    // Full write, then a read of the same place in the very next cycle
    task automatic wrRd(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        cfgWrEn = 1'b1;
        cfgAddr = a;
        cfgWrData = d;
        cfgByteEn = 4'hf;
        @(negedge clk);
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b1;
        @(negedge clk);
        cfgRdEn = 1'b0;
        mdlWrite(a, d, 4'hf);
        chk(cfgRdValid, 1'b1, "back to back valid");
        chk(cfgRdData, expRead(a), "back to back data");
    endtask : wrRd

    task automatic outChk();
        logic [2:0] m;
        m = mdl[5][22:20];
        @(negedge clk);
        chk(msgIntEnable, mdl[5][16], "enable out");
        chk(msgIntPermitted, !mdl[5][16], "permit out");
        chk(vectorsAllocated, m, "alloc code");
        chk(vectorsAllocatedCount, m[2] ? 4'h0 : 4'h1 << m, "count");
    endtask : outChk

    task automatic xlat(input logic [63:0] a);
        logic [63:0] b;
        logic [63:0] l;
        logic [63:0] p;
        logic h;
        b = {mdl[2], mdl[1][31:20], 20'h0};
        l = {mdl[4], mdl[3][31:20], 20'hfffff};
        p = {mdl[0], remapLowerBasePrimary, 20'h0};
        h = remapEnable && b <= a && a <= l;
        @(negedge clk);
        txnValid = 1'b1;
        txnAddr = a;
        @(negedge clk);
        txnValid = 1'b0;
        chk(xlatValid, 1'b1, "xlat valid");
        chk(xlatHit, h, "xlat hit");
        chk(xlatAddr, h ? p + (a - b) : a, "xlat addr");
    endtask : xlat

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        $display("[FAIL] %0t watchdog expired", $time);
        endSim();
    end

    initial begin
        logic [11:0] a;
        logic [31:0] d;
        logic [63:0] lo;
        logic [63:0] hi;
        void'($urandom(32'hbb268e3f));
        for (int i = 0; i < 5; i++) mdl[i] = RST_REMAP;
        mdl[5] = RST_MSI_HDR;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rdChk(ofs[i]);
        outChk();
        rdChk(OFS_CAP_PTR);
        chk(capListStart, LIST_START, "list start");
        chk(firstExtCapOffset, OFS_EXT_CAP_FIRST, "ext cap");
        // random lanes, reserved bits and unmapped places
        for (int n = 0; n < 60; n++) begin
            a = (n % 10 == 0) ? 12'h084 : ofs[$urandom_range(5, 0)];
            d = $urandom();
            if (a == OFS_MSI_HDR) d[22] = 1'b0;
            wr(a, d, 4'($urandom_range(15, 0)));
            rdChk(a);
        end
        // Same-cycle read and write returns the old value
        d = $urandom();
        acc(1'b1, 1'b1, ofs[0], d, 4'hf);
        chk(cfgRdData, mdl[0], "read beside write");
        mdlWrite(ofs[0], d, 4'hf);
        rdChk(ofs[0]);
        // every legal allocation code, enable off and on
        for (int c = 0; c < 8; c++) begin
            wr(OFS_MSI_HDR, {10'h0, c[1:0], 3'h0, c[2], 16'h0}, 4'hf);
            outChk();
            rdChk(OFS_MSI_HDR);
        end
        // Clock enable low keeps the registers frozen
        ce = 1'b0;
        acc(1'b1, 1'b0, ofs[0], ~mdl[0], 4'hf);
        ce = 1'b1;
        rdChk(ofs[0]);
        // Back-to-back write and read return the new value
        wrRd(OFS_SEC_BASE_HIGH, $urandom());
        wrRd(OFS_MSI_HDR, $urandom() & 32'hffbfffff);
        d = $urandom();
        wr(ofs[0], $urandom(), 4'hf);
        wr(ofs[1], 32'h12300000, 4'hf);
        wr(ofs[2], d, 4'hf);
        wr(ofs[3], 32'h456fffff, 4'hf);
        wr(ofs[4], d, 4'hf);
        remapLowerBasePrimary = 12'($urandom());
        lo = {mdl[2], mdl[1][31:20], 20'h0};
        hi = {mdl[4], mdl[3][31:20], 20'hfffff};
        for (int e = 0; e < 2; e++) begin
            remapEnable = e[0];
            xlat(lo - 64'h1);
            xlat(lo);
            xlat(hi);
            xlat(hi + 64'h1);
            for (int k = 0; k < 6; k++) begin
                xlat(lo + 64'($urandom_range(32'h333fffff, 0)));
                xlat({$urandom(), $urandom()});
            end
        end
        endSim();
    end
endmodule : test_nrmc_cap_regs
